// *** pkg/ccc_regs.vh ***
// register offsets, field positions and reset values of the clock configuration block
`ifndef CCC_REGS_VH
`define CCC_REGS_VH
`define CCC_OFF_CLKSEL 9'h030
`define CCC_OFF_FASTTRIM 9'h034
`define CCC_OFF_SLOWTRIM 9'h036
`define CCC_OFF_LOCK 9'h039
`define CCC_OFF_SPEED 9'h1e0
`define CCC_OFF_SLEEP 9'h040
`define CCC_OFF_STATUS 9'h041
`define CCC_CLKSEL_CORE 0
`define CCC_CLKSEL_USB 5
`define CCC_CLKSEL_NODIV 6
`define CCC_CLKSEL_MASK 8'h61
`define CCC_SLOW_LP 7
`define CCC_SLOW_MASK 8'hbf
`define CCC_SLOW_RESET 8'h00
`define CCC_FAST_RESET 8'h00
`define CCC_LOCK_DIS 0
`define CCC_LOCK_FINE 1
`define CCC_LOCK_MASK 8'h03
`define CCC_SPEED_MASK 8'h3f
`define CCC_SPEED_NOBUZZ 5
`define CCC_RESET_BYTE 8'h00
`define CCC_SLOW_PERIOD_NS 31250
`define CCC_CLK_PERIOD_NS 5
`define CCC_WAKE_SLOW_CYCLES 3
`endif

// *** design/ccc_divider.v ***
// core clock enable divider: produces a one-cycle tick every divide ratio source cycles
`include "ccc_regs.vh"
module ccc_divider
(
	// clock and reset
	input wire clk,
	input wire rst_n,
	// control
	input wire [2:0] speedCode,
	// result
	output reg coreTick
);
	reg [6:0] count_q;
	reg [7:0] ratio;
	// speed code to divide ratio
	function [7:0] speedRatio;
		input [2:0] code;
		begin
			case (code)
				3'h0: speedRatio = 8'h08;
				3'h1: speedRatio = 8'h04;
				3'h2: speedRatio = 8'h02;
				3'h3: speedRatio = 8'h01;
				3'h4: speedRatio = 8'h10;
				3'h5: speedRatio = 8'h20;
				3'h6: speedRatio = 8'h80;
				default: speedRatio = 8'h08;
			endcase
		end
	endfunction
	always @*
	begin
		ratio = speedRatio(speedCode);
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= 7'h00;
			coreTick <= 1'b0;
		end
		else if ({1'b0, count_q} >= ratio - 8'h01)
		begin
			count_q <= 7'h00;
			coreTick <= 1'b1;
		end
		else
		begin
			count_q <= count_q + 7'h01;
			coreTick <= 1'b0;
		end
	end
endmodule // ccc_divider

// *** design/ccc_sync.v ***
// two flip-flop synchroniser for a single level
module ccc_sync
(
	// clock and reset
	input wire clk,
	input wire rst_n,
	// data
	input wire asyncIn,
	output reg syncOut
);
	reg meta_q;
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 1'b0;
			syncOut <= 1'b0;
		end
		else
		begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // ccc_sync

// *** design/ccc_clock_config.v ***
// core and usb clock configuration registers with sleep override and packet lock control
//
// Notes on behaviour
// R1: three fine-offset bits add binary-weighted steps to fast oscillator; factory leaves zero
// R2: five-bit gain field scales offset step; lower value means larger effect
// R3: slow oscillator trim fields undefined until boot code loads calibration
// R4: slow trim bit 7 selects low-power mode of slow oscillator
// R5: software never writes bias value 10b; encodings 00 mid, 01 high
// R6: software rewrites bias and frequency trims unchanged when toggling low-power bit
// R7: usb divide-by-two disable acts only with external usb source
// R8: software sets divide disable only with a 12 MHz external clock
// R9: usb select 0 internal oscillator, 1 external; external stops packet retuning
// R10: core select 0 internal oscillator, 1 external pin; resets to 0
// R11: core speed codes 0..6 divide by 8,4,2,1,16,32,128; 7 reserved
// R12: core speed resets to zero, so core starts at one eighth
// R13: software keeps core clock at least usb/8 and at least 1.5 MHz
// R14: detector-always-on bit keeps detector on in sleep, else duty cycled
// R15: speed register sits in second io bank; software sets bank select first
// R16: packet lock active only while internal oscillator feeds the usb engine
// R17: lock disable bit 0 lets lock tune oscillator; 1 stops packet trimming
// R18: fine-tune-only bit stops coarse retuning after coarse tuning completed
// R19: sleep forces core to internal oscillator; wake waits three slow cycles
// R20: reserved bits read zero and ignore writes
`include "ccc_regs.vh"
module ccc_clock_config
#(
	parameter WAKE_CYCLES = (`CCC_WAKE_SLOW_CYCLES * `CCC_SLOW_PERIOD_NS
		+ `CCC_CLK_PERIOD_NS - 1) / `CCC_CLK_PERIOD_NS
)
(
	// clock and reset
	input wire clk,
	input wire rst_n,
	// register port
	input wire [8:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData,
	// system state from pins
	input wire sleepReqPin,
	input wire usbTrafficPin,
	input wire coarseDonePin,
	// oscillator trims
	output reg [2:0] fastOffset,
	output reg [4:0] fastGain,
	output reg slowLowPower,
	output reg [1:0] slowBias,
	output reg [3:0] slowFreqTrim,
	// clock selection
	output reg coreUseExt,
	output reg coreTickOut,
	output reg usbUseExt,
	output reg usbDivideByTwo,
	// detector and lock
	output reg detectorAlwaysOn,
	output reg [1:0] sleepTimer,
	output reg lockCoarseEn,
	output reg lockFineEn
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [7:0] clkSel_q;
	reg [7:0] fastTrim_q;
	reg [7:0] slowTrim_q;
	reg [7:0] lock_q;
	reg [7:0] speed_q;
	reg sleeping_q;
	reg [1:0] wakeState_q;
	reg [17:0] wakeCount_q;
	reg [7:0] readMux;
	wire sleepReq;
	wire usbTraffic;
	wire coarseDone;
	wire rawTick;
	localparam ST_RUN = 2'b00;
	localparam ST_SLEEP = 2'b01;
	localparam ST_WAKE = 2'b10;
	localparam integer WAKE_SPAN = WAKE_CYCLES - 1;
	// the wake counter is 18 bits wide, enough for the default recovery span
	localparam [17:0] WAKE_LAST = WAKE_SPAN[17:0];
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	ccc_sync uSyncSleep
	(
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(sleepReqPin),
		.syncOut(sleepReq)
	);
	ccc_sync uSyncTraffic
	(
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(usbTrafficPin),
		.syncOut(usbTraffic)
	);
	ccc_sync uSyncCoarse
	(
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(coarseDonePin),
		.syncOut(coarseDone)
	);
	// ----------------------------------------------------------------
	// core divider
	// ----------------------------------------------------------------
	ccc_divider uDiv
	(
		.clk(clk),
		.rst_n(rst_n),
		.speedCode(speed_q[2:0]),
		.coreTick(rawTick)
	);
	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// trims have no defined power-on value in silicon; zero here keeps simulation clean
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clkSel_q <= `CCC_RESET_BYTE; // [R10]
			fastTrim_q <= `CCC_FAST_RESET; // [R1]
			slowTrim_q <= `CCC_SLOW_RESET; // [R3]
			lock_q <= `CCC_RESET_BYTE;
			speed_q <= `CCC_RESET_BYTE; // [R12]
		end
		else
		begin
			if (regWrite && regAddr == `CCC_OFF_CLKSEL)
				clkSel_q <= regWrData & `CCC_CLKSEL_MASK; // [R20]
			else if (sleepReq)
				clkSel_q[`CCC_CLKSEL_CORE] <= 1'b0; // [R19]
			if (regWrite && regAddr == `CCC_OFF_FASTTRIM)
				fastTrim_q <= regWrData; // [R1] [R2]
			if (regWrite && regAddr == `CCC_OFF_SLOWTRIM)
				slowTrim_q <= regWrData & `CCC_SLOW_MASK; // [R3] [R20]
			if (regWrite && regAddr == `CCC_OFF_LOCK)
				lock_q <= regWrData & `CCC_LOCK_MASK; // [R20]
			if (regWrite && regAddr == `CCC_OFF_SPEED)
				speed_q <= regWrData & `CCC_SPEED_MASK; // [R20]
		end
	end
	// ----------------------------------------------------------------
	// sleep and wake sequencing
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wakeState_q <= ST_RUN;
			wakeCount_q <= 18'h0_0000;
			sleeping_q <= 1'b0;
		end
		else
		begin
			case (wakeState_q)
				ST_RUN:
					if (sleepReq)
					begin
						wakeState_q <= ST_SLEEP;
						sleeping_q <= 1'b1;
					end
				ST_SLEEP:
					if (!sleepReq)
					begin
						wakeState_q <= ST_WAKE;
						wakeCount_q <= 18'h0_0000;
					end
				ST_WAKE:
					if (wakeCount_q == WAKE_LAST)
					begin
						wakeState_q <= ST_RUN;
						sleeping_q <= 1'b0; // [R19]
					end
					else
						wakeCount_q <= wakeCount_q + 18'h0_0001;
				default:
					wakeState_q <= ST_RUN;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always @*
	begin
		case (regAddr)
			`CCC_OFF_CLKSEL: readMux = clkSel_q;
			`CCC_OFF_FASTTRIM: readMux = fastTrim_q;
			`CCC_OFF_SLOWTRIM: readMux = slowTrim_q;
			`CCC_OFF_LOCK: readMux = lock_q;
			`CCC_OFF_SPEED: readMux = speed_q;
			`CCC_OFF_STATUS: readMux = {5'h00, usbTraffic, wakeState_q};
			default: readMux = 8'h00; // [R20]
		endcase
	end
	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regRdData <= 8'h00;
			fastOffset <= 3'h0;
			fastGain <= 5'h00;
			slowLowPower <= 1'b0;
			slowBias <= 2'h0;
			slowFreqTrim <= 4'h0;
			coreUseExt <= 1'b0;
			coreTickOut <= 1'b0;
			usbUseExt <= 1'b0;
			usbDivideByTwo <= 1'b1;
			detectorAlwaysOn <= 1'b0;
			sleepTimer <= 2'h0;
			lockCoarseEn <= 1'b0;
			lockFineEn <= 1'b0;
		end
		else
		begin
			regRdData <= regRead ? readMux : 8'h00;
			fastOffset <= fastTrim_q[7:5]; // [R1]
			fastGain <= fastTrim_q[4:0]; // [R2]
			slowLowPower <= slowTrim_q[`CCC_SLOW_LP]; // [R4]
			slowBias <= slowTrim_q[5:4];
			slowFreqTrim <= slowTrim_q[3:0];
			// core stays internal from sleep entry until wake recovery ends
			coreUseExt <= clkSel_q[`CCC_CLKSEL_CORE] && !sleeping_q; // [R10] [R19]
			// no core ticks while asleep or recovering
			coreTickOut <= rawTick && !sleeping_q; // [R11]
			usbUseExt <= clkSel_q[`CCC_CLKSEL_USB]; // [R9]
			usbDivideByTwo <= !(clkSel_q[`CCC_CLKSEL_USB]
				&& clkSel_q[`CCC_CLKSEL_NODIV]); // [R7]
			detectorAlwaysOn <= speed_q[`CCC_SPEED_NOBUZZ]; // [R14]
			sleepTimer <= speed_q[4:3];
			// lock runs only on internal usb source, enabled, and with traffic
			lockFineEn <= !clkSel_q[`CCC_CLKSEL_USB] && !lock_q[`CCC_LOCK_DIS]
				&& usbTraffic; // [R16] [R17]
			lockCoarseEn <= !clkSel_q[`CCC_CLKSEL_USB] && !lock_q[`CCC_LOCK_DIS]
				&& usbTraffic && !(lock_q[`CCC_LOCK_FINE] && coarseDone); // [R18]
		end
	end
endmodule // ccc_clock_config

// *** test/ccc_clock_config_sva.sv ***
// assertion checker for the clock configuration block
`include "ccc_regs.vh"
module ccc_clock_config_sva
(
	// every port of the block, observed only
	input logic clk, rst_n, regWrite, regRead, sleepReqPin, usbTrafficPin, coarseDonePin,
	input logic [8:0] regAddr,
	input logic [7:0] regWrData, regRdData,
	input logic [2:0] fastOffset,
	input logic [4:0] fastGain,
	input logic [1:0] slowBias, sleepTimer,
	input logic [3:0] slowFreqTrim,
	input logic slowLowPower, coreUseExt, coreTickOut, usbUseExt, usbDivideByTwo,
	input logic detectorAlwaysOn, lockCoarseEn, lockFineEn
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// write decodes and field views
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire wrSel = regWrite && regAddr == `CCC_OFF_CLKSEL;
	wire wrSpd = regWrite && regAddr == `CCC_OFF_SPEED;
	wire wrSlow = regWrite && regAddr == `CCC_OFF_SLOWTRIM;
	wire wrFast = regWrite && regAddr == `CCC_OFF_FASTTRIM;
	wire wrLock = regWrite && regAddr == `CCC_OFF_LOCK;
	wire [6:0] slowVal = {regWrData[7], regWrData[5:0]};
	wire [2:0] spdVal = regWrData[5:3];
	a_read_slot_only: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside its slot");
	a_fast_trim_out: assert property (wrFast |-> ##2 {fastOffset, fastGain} == $past(regWrData, 2))
		else $error("fast trim outputs differ from write");
	a_slow_trim_out: assert property (wrSlow |-> ##2 {slowLowPower, slowBias, slowFreqTrim} == $past(slowVal, 2))
		else $error("slow trim outputs differ from write");
	a_detector_fields: assert property (wrSpd |-> ##2 {detectorAlwaysOn, sleepTimer} == $past(spdVal, 2))
		else $error("detector fields differ from write");
	a_usb_undivided: assert property (wrSel && regWrData[6:5] == 2'b11 |-> ##2 !usbDivideByTwo)
		else $error("external usb clock still divided");
	a_lock_ext_off: assert property (usbUseExt |-> !lockFineEn && !lockCoarseEn)
		else $error("lock active on external usb source");
	a_coarse_with_fine: assert property (lockCoarseEn |-> lockFineEn)
		else $error("coarse tuning without lock");
	a_lock_disabled: assert property (wrLock && regWrData[0] |-> ##2 !lockFineEn)
		else $error("lock still active after disable");
	a_sleep_internal: assert property (sleepReqPin [*6] |-> !coreTickOut && !coreUseExt)
		else $error("core clock runs or external in sleep");
	c_coarse: cover property (lockCoarseEn);
	c_nodiv: cover property (usbUseExt && !usbDivideByTwo);
	c_sleep: cover property (sleepReqPin [*6]);
endmodule // ccc_clock_config_sva
bind ccc_clock_config ccc_clock_config_sva u_sva (.*);

// *** test/testbench.sv ***
// self-checking testbench for the clock configuration block
`include "ccc_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, regWrite = 0, regRead = 0;
	logic sleepReqPin = 0, usbTrafficPin = 0, coarseDonePin = 0;
	logic [8:0] regAddr = 9'h000;
	logic [7:0] regWrData = 8'h00, regRdData;
	logic [2:0] fastOffset;
	logic [4:0] fastGain;
	logic [1:0] slowBias, sleepTimer;
	logic [3:0] slowFreqTrim;
	logic slowLowPower, coreUseExt, coreTickOut, usbUseExt, usbDivideByTwo;
	logic detectorAlwaysOn, lockCoarseEn, lockFineEn;
	int n_mismatch = 0, compares = 0;
	// reserved code 7 falls back to divide by 8
	logic [7:0] ratio [8] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h10, 8'h20, 8'h80, 8'h08};
	// short wake count keeps the sleep test brief
	ccc_clock_config #(.WAKE_CYCLES(4)) DUT (.*);
	always #2.5 clk = ~clk;
	// ----------------------------------------
	// bus cycles and comparison
	// ----------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [8:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regRdData, exp);
	endtask
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task count_ticks(output int n);
		n = 0;
		repeat (20)
		begin
			@(posedge clk);
			#1;
			n += coreTickOut;
		end
	endtask
	// edges up to and including the next core tick, looked at once settled
	task next_tick(output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (coreTickOut !== 1'b1 && n < 200);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(`CCC_OFF_CLKSEL, 8'h00);
		rd(`CCC_OFF_SPEED, 8'h00);
		rd(`CCC_OFF_LOCK, 8'h00);
		chk({7'h00, usbDivideByTwo}, 8'h01);
		$display("reset test done");
	endtask
	task t_clksel;
		usbTrafficPin <= 1'b1;
		wr(`CCC_OFF_CLKSEL, 8'hff);
		rd(`CCC_OFF_CLKSEL, 8'h61);
		settle();
		chk({coreUseExt, usbUseExt, usbDivideByTwo, lockFineEn}, 8'h0c);
		wr(`CCC_OFF_CLKSEL, 8'h20);
		settle();
		chk({coreUseExt, usbUseExt, usbDivideByTwo, lockFineEn}, 8'h06);
		wr(`CCC_OFF_CLKSEL, 8'h40);
		settle();
		chk({coreUseExt, usbUseExt, usbDivideByTwo, lockFineEn}, 8'h03);
		wr(9'h040, 8'hff);
		rd(9'h040, 8'h00);
		rd(`CCC_OFF_STATUS, 8'h04);
		$display("clock select test done");
	endtask
	task t_lock;
		coarseDonePin <= 1'b1;
		wr(`CCC_OFF_LOCK, 8'h00);
		settle();
		chk({lockCoarseEn, lockFineEn}, 8'h03);
		wr(`CCC_OFF_LOCK, 8'h02);
		settle();
		chk({lockCoarseEn, lockFineEn}, 8'h01);
		wr(`CCC_OFF_LOCK, 8'hff);
		rd(`CCC_OFF_LOCK, 8'h03);
		chk({lockCoarseEn, lockFineEn}, 8'h00);
		wr(`CCC_OFF_LOCK, 8'h00);
		usbTrafficPin <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk({lockCoarseEn, lockFineEn}, 8'h00);
		$display("lock test done");
	endtask
	task t_trim;
		wr(`CCC_OFF_FASTTRIM, 8'hff);
		rd(`CCC_OFF_FASTTRIM, 8'hff);
		chk({fastOffset, fastGain}, 8'hff);
		wr(`CCC_OFF_SLOWTRIM, 8'h1a);
		rd(`CCC_OFF_SLOWTRIM, 8'h1a);
		wr(`CCC_OFF_SLOWTRIM, 8'hda);
		rd(`CCC_OFF_SLOWTRIM, 8'h9a);
		chk({slowLowPower, 1'b0, slowBias, slowFreqTrim}, 8'h9a);
		$display("trim test done");
	endtask
	task t_speed;
		int n;
		wr(`CCC_OFF_SPEED, 8'hf8);
		rd(`CCC_OFF_SPEED, 8'h38);
		chk({detectorAlwaysOn, sleepTimer}, 8'h07);
		for (int c = 0; c < 8; c++)
		begin
			wr(`CCC_OFF_SPEED, 8'(c));
			// the first gap may straddle the ratio change
			repeat (3) next_tick(n);
			chk(n[7:0], ratio[c]);
		end
		chk({detectorAlwaysOn, sleepTimer}, 8'h00);
		$display("speed test done");
	endtask
	task t_sleep;
		int n;
		wr(`CCC_OFF_SPEED, 8'h03);
		wr(`CCC_OFF_CLKSEL, 8'h01);
		sleepReqPin <= 1'b1;
		repeat (8) @(posedge clk);
		count_ticks(n);
		chk({coreUseExt, n[6:0]}, 8'h00);
		rd(`CCC_OFF_CLKSEL, 8'h00);
		rd(`CCC_OFF_STATUS, 8'h01);
		sleepReqPin <= 1'b0;
		count_ticks(n);
		chk({6'h00, coreUseExt, n != 0}, 8'h01);
		$display("sleep test done");
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_clksel();
		t_lock();
		t_trim();
		t_speed();
		t_sleep();
		wrap_up();
	end
	// whole run needs about 750 cycles
	initial
	begin
		#50us;
		n_mismatch++;
		wrap_up();
	end
endmodule // testbench
